// >>> logic/iss_params.svh
// offsets, field positions, reset values and widths of the interrupt summary block
// Summary of operation
// [RULE1] Summary bits 17 to 31 each show descriptor interrupt n enabled and flagged, n = 1 to 15.
// [RULE2] Summary bit 13 shows that any bit of the time-sync enable or status word is set.
// [RULE3] Summary bit 12 shows the receive FIFO warning flag with its enable set.
// [RULE4] Summary bit 9 shows the time-stamp FIFO warning flag with its enable set.
// [RULE5] Summary bit 8 shows the time-stamp FIFO update flag with its enable set.
// [RULE6] Summary bit 7 follows the MAC interrupt request and is 0 when it is idle.
// [RULE7] Summary bit 6 shows that some error status bit has its matching enable set.
// [RULE8] Summary bit 2 shows that some transmit queue has both done flag and enable set.
// [RULE9] Summary bit 0 shows that some receive queue has both frame flag and enable set.
// [RULE10] Summary bits 16 to 14, 11 to 10, 5 to 3 and 1 always read as 0.
// [RULE11] A transmit queue's done flag sets when the MAC has sent a frame of it, clears on leaving operation mode.
// [RULE12] Summary bits other than 13 and 7 follow their flag and enable and fall as soon as either is 0.
// [RULE13] Writes to the summary word change nothing, and it reads 0 after reset.
`ifndef ISS_PARAMS_SVH
`define ISS_PARAMS_SVH

// register byte offsets
`define ISS_OFF_SUMMARY     8'h00
`define ISS_OFF_TXDONE_FLAG 8'h04
`define ISS_OFF_TXDONE_EN   8'h08
`define ISS_OFF_IRQ_STATUS  8'h0c
`define ISS_OFF_IRQ_MASK    8'h10

// summary bit positions
`define ISS_BIT_DESC_LO     17
`define ISS_BIT_TIME_SYNC   13
`define ISS_BIT_RX_FIFO_WARN 12
`define ISS_BIT_TS_FIFO_WARN 9
`define ISS_BIT_TS_FIFO_UPD 8
`define ISS_BIT_MAC         7
`define ISS_BIT_ERROR       6
`define ISS_BIT_TX_DONE     2
`define ISS_BIT_RX_FRAME    0

// bits that can ever be 1 in the summary word
`define ISS_SUMMARY_USED    32'hfffe_33c5

// reset values
`define ISS_RST_WORD        32'h0000_0000

// default widths of source groups
`define ISS_TX_QUEUES       4
`define ISS_RX_QUEUES       4
`define ISS_ERR_BITS        32
`define ISS_TSYNC_BITS      32

// bus answers
`define ISS_RESP_OKAY       2'h0
`define ISS_RESP_SLVERR     2'h2

`endif

// >>> logic/iss_pkg.sv
// types shared by the interrupt summary block
package iss_pkg;

    typedef logic [31:0] iss_word_t;
    typedef logic [7:0]  iss_addr_t;
    typedef logic [1:0]  iss_resp_t;
    typedef logic [3:0]  iss_strb_t;

endpackage

// >>> logic/iss_txdone_flags.sv
// per-queue frame transmitted flags with hardware set and software clear
`timescale 1ns/1ps
`default_nettype none

module iss_txdone_flags #(
    parameter int NQ = 4
) (
    // clock and reset
    input  wire logic          aclk,
    input  wire logic          aresetn,
    // events from the mac
    input  wire logic [NQ-1:0] tx_frame_sent,
    input  wire logic          op_mode,
    // software clear, a 0 written in an enabled lane clears the flag
    input  wire logic          sw_we,
    input  wire logic [NQ-1:0] sw_keep,
    // flags
    output logic      [NQ-1:0] tx_frame_done_flag_q
);
    typedef struct packed {
        logic [NQ-1:0] flag;
        logic          op_prev;
    } iss_txd_state_t;

    iss_txd_state_t st_r;
    iss_txd_state_t st_nxt;
    logic           leave_op;

    // next flags: set beats software clear, so a frame ending in the clear cycle is kept
    always_comb begin
        st_nxt = st_r;
        leave_op = st_r.op_prev & ~op_mode;
        st_nxt.op_prev = op_mode;
        if (sw_we) begin
            st_nxt.flag = st_r.flag & sw_keep;
        end
        // [RULE11] set on sent frame
        st_nxt.flag = st_nxt.flag | tx_frame_sent;
        // [RULE11] clear leaving operation
        if (leave_op) begin
            st_nxt.flag = '0;
        end
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tx_frame_done_flag_q = st_r.flag;

endmodule
`default_nettype wire

// >>> logic/iss_top.sv
// interrupt summary status word with axi4-lite slave and interrupt output
`timescale 1ns/1ps
`default_nettype none
`include "iss_params.svh"

module iss_top #(
    parameter int NQ_TX   = `ISS_TX_QUEUES,
    parameter int NQ_RX   = `ISS_RX_QUEUES,
    parameter int ERR_W   = `ISS_ERR_BITS,
    parameter int TSYNC_W = `ISS_TSYNC_BITS
) (
    // clock and reset
    input  wire logic               aclk,
    input  wire logic               aresetn,

    // axi4-lite write address
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_awaddr,
    input  wire logic [2:0]         s_axi_awprot,

    // axi4-lite write data
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    input  wire iss_pkg::iss_word_t s_axi_wdata,
    input  wire iss_pkg::iss_strb_t s_axi_wstrb,

    // axi4-lite write response
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    output iss_pkg::iss_resp_t      s_axi_bresp,

    // axi4-lite read address
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    input  wire logic [31:0]        s_axi_araddr,
    input  wire logic [2:0]         s_axi_arprot,

    // axi4-lite read data
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    output iss_pkg::iss_word_t      s_axi_rdata,
    output iss_pkg::iss_resp_t      s_axi_rresp,

    // descriptor interrupt sources, index 1 to 15
    input  wire logic [15:1]        descriptor_irq_enable_n,
    input  wire logic [15:1]        descriptor_irq_flag_n,

    // time-sync enable and status words
    input  wire logic [TSYNC_W-1:0] time_sync_irq_enable_reg,
    input  wire logic [TSYNC_W-1:0] time_sync_irq_status_reg,

    // fifo warning and update sources
    input  wire logic               rx_fifo_warn_enable,
    input  wire logic               rx_fifo_warn_flag,
    input  wire logic               tstamp_fifo_warn_enable,
    input  wire logic               tstamp_fifo_warn_flag,
    input  wire logic               tstamp_fifo_update_enable,
    input  wire logic               tstamp_fifo_update_flag,

    // mac and error sources
    input  wire logic               mac_irq,
    input  wire logic [ERR_W-1:0]   error_status_reg,
    input  wire logic [ERR_W-1:0]   error_enable_reg,

    // transmit side: frame sent pulses and operation mode level
    input  wire logic [NQ_TX-1:0]   tx_frame_sent,
    input  wire logic               op_mode,

    // receive side per-queue flags and enables
    input  wire logic [NQ_RX-1:0]   rx_frame_enable_q,
    input  wire logic [NQ_RX-1:0]   rx_frame_flag_q,

    // results
    output iss_pkg::iss_word_t      interrupt_summary,
    output logic [NQ_TX-1:0]        tx_frame_done_flag_q,
    output logic                    irq
);
    import iss_pkg::*;

    typedef struct packed {
        // write channel holding
        logic      awready;
        logic      aw_held;
        iss_addr_t aw_addr;
        logic      wready;
        logic      w_held;
        iss_word_t w_data;
        iss_strb_t w_strb;
        logic      bvalid;
        iss_resp_t bresp;

        // read channel
        logic      arready;
        logic      rvalid;
        iss_word_t rdata;
        iss_resp_t rresp;

        // block state
        iss_word_t summary;
        iss_word_t status;
        iss_word_t mask;
        logic [NQ_TX-1:0] tx_en;
        logic      irq;
    } iss_state_t;

    // registered state and its next value
    iss_state_t         st_r;
    iss_state_t         st_nxt;
    // decode strobes and the flag keeper link
    iss_word_t          live_sum;
    logic               do_write;
    logic               do_read;
    logic [NQ_TX-1:0]   txd_flag;
    logic               txd_we;
    logic [NQ_TX-1:0]   txd_keep;

    // any position where both words carry a 1
    function automatic logic any_pair(input iss_word_t a, input iss_word_t b);
        any_pair = |(a & b);
    endfunction

    // byte-lane merge of a written word into a stored one
    function automatic iss_word_t merge_strb(input iss_word_t old_v, input iss_word_t new_v,
                                             input iss_strb_t strb);
        iss_word_t res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        merge_strb = res;
    endfunction

    // live summary word built from source flags and enables
    always_comb begin
        live_sum = `ISS_RST_WORD;
        // [RULE1] descriptor n summaries
        live_sum[31:`ISS_BIT_DESC_LO] = descriptor_irq_enable_n & descriptor_irq_flag_n;
        // [RULE2] any time-sync bit
        live_sum[`ISS_BIT_TIME_SYNC] = (|time_sync_irq_enable_reg) |
                                       (|time_sync_irq_status_reg);
        // [RULE3] receive fifo warning
        live_sum[`ISS_BIT_RX_FIFO_WARN] = rx_fifo_warn_enable & rx_fifo_warn_flag;
        // [RULE4] time-stamp fifo warning
        live_sum[`ISS_BIT_TS_FIFO_WARN] = tstamp_fifo_warn_enable & tstamp_fifo_warn_flag;
        // [RULE5] time-stamp fifo update
        live_sum[`ISS_BIT_TS_FIFO_UPD] = tstamp_fifo_update_enable & tstamp_fifo_update_flag;
        // [RULE6] mac request follows
        live_sum[`ISS_BIT_MAC] = mac_irq;
        // [RULE7] matching error pair
        live_sum[`ISS_BIT_ERROR] = any_pair(32'(error_status_reg), 32'(error_enable_reg));
        // [RULE8] matching transmit queue
        live_sum[`ISS_BIT_TX_DONE] = any_pair(32'(txd_flag), 32'(st_r.tx_en));
        // [RULE9] matching receive queue
        live_sum[`ISS_BIT_RX_FRAME] = any_pair(32'(rx_frame_flag_q), 32'(rx_frame_enable_q));
        // [RULE10] unused positions forced low
        live_sum = live_sum & `ISS_SUMMARY_USED;
    end

    // only the low address byte is decoded, so the map repeats every 256 bytes
    // a write happens once both halves are held and the previous answer is gone
    assign do_write = st_r.aw_held & st_r.w_held & ~st_r.bvalid;
    assign do_read  = s_axi_arvalid & st_r.arready;

    // the only software clear reaching the flags: a 0 in an enabled byte lane
    assign txd_we   = do_write & (st_r.aw_addr == `ISS_OFF_TXDONE_FLAG) & st_r.w_strb[0];
    assign txd_keep = st_r.w_data[NQ_TX-1:0];

    // next state of bus slave, summary, status and mask
    always_comb begin
        iss_word_t events;
        iss_word_t clr;
        st_nxt = st_r;
        events = `ISS_RST_WORD;
        clr    = `ISS_RST_WORD;

        // write address and data are taken independently, in either order
        if (s_axi_awvalid && st_r.awready) begin
            st_nxt.aw_held = 1'b1;
            st_nxt.aw_addr = s_axi_awaddr[7:0];
        end
        if (s_axi_wvalid && st_r.wready) begin
            st_nxt.w_held = 1'b1;
            st_nxt.w_data = s_axi_wdata;
            st_nxt.w_strb = s_axi_wstrb;
        end

        // register write decode
        if (do_write) begin
            st_nxt.aw_held = 1'b0;
            st_nxt.w_held  = 1'b0;
            st_nxt.bvalid  = 1'b1;
            st_nxt.bresp   = `ISS_RESP_OKAY;
            if (st_r.aw_addr == `ISS_OFF_SUMMARY) begin
                // [RULE13] summary write ignored
                st_nxt.bresp = `ISS_RESP_OKAY;
            end else if (st_r.aw_addr == `ISS_OFF_TXDONE_FLAG) begin
                // flag clearing is done inside the flag keeper
                st_nxt.bresp = `ISS_RESP_OKAY;
            end else if (st_r.aw_addr == `ISS_OFF_TXDONE_EN) begin
                // low queue bits only, lanes honoured
                st_nxt.tx_en = NQ_TX'(merge_strb(32'(st_r.tx_en), st_r.w_data, st_r.w_strb));
            end else if (st_r.aw_addr == `ISS_OFF_IRQ_STATUS) begin
                // write one to clear
                clr = merge_strb(`ISS_RST_WORD, st_r.w_data, st_r.w_strb);
            end else if (st_r.aw_addr == `ISS_OFF_IRQ_MASK) begin
                // unused positions never unmask
                st_nxt.mask = merge_strb(st_r.mask, st_r.w_data, st_r.w_strb)
                              & `ISS_SUMMARY_USED;
            end else begin
                // unmapped offset
                st_nxt.bresp = `ISS_RESP_SLVERR;
            end
        end else if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end

        // ready only while the holding slot is free, so a pending write stalls the master
        st_nxt.awready = ~st_nxt.aw_held;
        st_nxt.wready  = ~st_nxt.w_held;

        // register read decode, one read at a time
        if (do_read) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp  = `ISS_RESP_OKAY;
            if (s_axi_araddr[7:0] == `ISS_OFF_SUMMARY) begin
                // same word as the port
                st_nxt.rdata = st_r.summary;
            end else if (s_axi_araddr[7:0] == `ISS_OFF_TXDONE_FLAG) begin
                // flags from the keeper
                st_nxt.rdata = 32'(txd_flag);
            end else if (s_axi_araddr[7:0] == `ISS_OFF_TXDONE_EN) begin
                // upper bits read 0
                st_nxt.rdata = 32'(st_r.tx_en);
            end else if (s_axi_araddr[7:0] == `ISS_OFF_IRQ_STATUS) begin
                // sticky events
                st_nxt.rdata = st_r.status;
            end else if (s_axi_araddr[7:0] == `ISS_OFF_IRQ_MASK) begin
                // interrupt mask
                st_nxt.rdata = st_r.mask;
            end else begin
                // unmapped reads zero with an error
                st_nxt.rdata = `ISS_RST_WORD;
                st_nxt.rresp = `ISS_RESP_SLVERR;
            end
        end else if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        st_nxt.arready = ~st_nxt.rvalid;

        // [RULE12] summary tracks sources each cycle
        st_nxt.summary = live_sum;

        // a rising summary bit is an event; set wins over a same-cycle clear
        events = live_sum & ~st_r.summary;
        st_nxt.status = (st_r.status & ~clr) | events;

        // level interrupt while any unmasked status bit stands
        st_nxt.irq = |(st_nxt.status & st_nxt.mask);
    end

    // state register; all but the three readies clear, the summary word reads 0 after reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // [RULE13] reset reads zero
            st_r         <= '0;
            // readies idle high, so a request is taken at the first edge
            st_r.awready <= 1'b1;
            st_r.wready  <= 1'b1;
            st_r.arready <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // per-queue frame transmitted flags
    iss_txdone_flags #(
        .NQ (NQ_TX)
    ) u_txdone (
        .aclk                 (aclk),
        .aresetn              (aresetn),
        .tx_frame_sent        (tx_frame_sent),
        .op_mode              (op_mode),
        .sw_we                (txd_we),
        .sw_keep              (txd_keep),
        .tx_frame_done_flag_q (txd_flag)
    );

    // outputs, all straight from flops
    assign s_axi_awready        = st_r.awready;
    assign s_axi_wready         = st_r.wready;
    assign s_axi_bvalid         = st_r.bvalid;
    assign s_axi_bresp          = st_r.bresp;
    // read side
    assign s_axi_arready        = st_r.arready;
    assign s_axi_rvalid         = st_r.rvalid;
    assign s_axi_rdata          = st_r.rdata;
    assign s_axi_rresp          = st_r.rresp;
    // summary, flags and interrupt
    assign interrupt_summary    = st_r.summary;
    assign tx_frame_done_flag_q = txd_flag;
    assign irq                  = st_r.irq;

endmodule
`default_nettype wire

// >>> verif/iss_checker.sv
// port assertions for the interrupt summary block
`timescale 1ns/1ps
`default_nettype none
`include "iss_params.svh"

module iss_checker #(
    parameter int NQ_TX   = 4,
    parameter int NQ_RX   = 4,
    parameter int ERR_W   = 32,
    parameter int TSYNC_W = 32
) (
    // clock and reset
    input wire logic               aclk,
    input wire logic               aresetn,
    // read channel
    input wire logic               s_axi_arvalid,
    input wire logic               s_axi_arready,
    input wire logic [31:0]        s_axi_araddr,
    input wire logic               s_axi_rvalid,
    input wire iss_pkg::iss_word_t s_axi_rdata,
    input wire iss_pkg::iss_resp_t s_axi_rresp,
    // sources
    input wire logic [15:1]        descriptor_irq_enable_n,
    input wire logic [15:1]        descriptor_irq_flag_n,
    input wire logic [TSYNC_W-1:0] time_sync_irq_enable_reg,
    input wire logic [TSYNC_W-1:0] time_sync_irq_status_reg,
    input wire logic               rx_fifo_warn_enable,
    input wire logic               rx_fifo_warn_flag,
    input wire logic               tstamp_fifo_warn_enable,
    input wire logic               tstamp_fifo_warn_flag,
    input wire logic               tstamp_fifo_update_enable,
    input wire logic               tstamp_fifo_update_flag,
    input wire logic               mac_irq,
    input wire logic [ERR_W-1:0]   error_status_reg,
    input wire logic [ERR_W-1:0]   error_enable_reg,
    input wire logic [NQ_TX-1:0]   tx_frame_sent,
    input wire logic               op_mode,
    input wire logic [NQ_RX-1:0]   rx_frame_enable_q,
    input wire logic [NQ_RX-1:0]   rx_frame_flag_q,
    // results
    input wire iss_pkg::iss_word_t interrupt_summary,
    input wire logic [NQ_TX-1:0]   tx_frame_done_flag_q
);
    import iss_pkg::*;

    // the summary word is registered, so every bit trails its sources by one edge
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_rd_sum;
        s_axi_arvalid && s_axi_arready && (s_axi_araddr[7:0] == `ISS_OFF_SUMMARY);
    endsequence

    sequence s_sent;
        op_mode && (tx_frame_sent != '0);
    endsequence

    AST_DESC: assert property (interrupt_summary[31:17] == $past(descriptor_irq_enable_n & descriptor_irq_flag_n))
        else $error("descriptor summary wrong");
    AST_TSYNC: assert property (interrupt_summary[13] == $past(|{time_sync_irq_enable_reg, time_sync_irq_status_reg}))
        else $error("time sync summary wrong");
    AST_RXWARN: assert property (interrupt_summary[12] == $past(rx_fifo_warn_enable && rx_fifo_warn_flag))
        else $error("rx fifo warn summary wrong");
    AST_TSWARN: assert property (interrupt_summary[9] == $past(tstamp_fifo_warn_enable && tstamp_fifo_warn_flag))
        else $error("tstamp warn summary wrong");
    AST_TSUPD: assert property (interrupt_summary[8] == $past(tstamp_fifo_update_enable && tstamp_fifo_update_flag))
        else $error("tstamp update summary wrong");
    AST_MAC: assert property (interrupt_summary[7] == $past(mac_irq))
        else $error("mac summary wrong");
    AST_ERR: assert property (interrupt_summary[6] == $past(|(error_status_reg & error_enable_reg)))
        else $error("error summary wrong");
    AST_TXSUM: assert property (interrupt_summary[2] |-> $past(tx_frame_done_flag_q) != '0)
        else $error("tx summary without flag");
    AST_RXSUM: assert property (interrupt_summary[0] == $past(|(rx_frame_enable_q & rx_frame_flag_q)))
        else $error("rx frame summary wrong");
    AST_RSVD: assert property ((interrupt_summary & ~`ISS_SUMMARY_USED) == 32'h0)
        else $error("reserved summary bit set");
    AST_TXSET: assert property (s_sent |=> (tx_frame_done_flag_q & $past(tx_frame_sent)) == $past(tx_frame_sent))
        else $error("tx done flag not set");
    AST_TXCLR: assert property ($fell(op_mode) |=> tx_frame_done_flag_q == '0)
        else $error("tx done flag not cleared");
    AST_RDSUM: assert property (s_rd_sum |=> s_axi_rvalid && s_axi_rdata == $past(interrupt_summary) && s_axi_rresp == 2'h0)
        else $error("summary readback wrong");
endmodule

bind iss_top iss_checker #(.NQ_TX(NQ_TX), .NQ_RX(NQ_RX), .ERR_W(ERR_W), .TSYNC_W(TSYNC_W)) u_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .descriptor_irq_enable_n(descriptor_irq_enable_n),
    .descriptor_irq_flag_n(descriptor_irq_flag_n), .time_sync_irq_enable_reg(time_sync_irq_enable_reg),
    .time_sync_irq_status_reg(time_sync_irq_status_reg), .rx_fifo_warn_enable(rx_fifo_warn_enable),
    .rx_fifo_warn_flag(rx_fifo_warn_flag), .tstamp_fifo_warn_enable(tstamp_fifo_warn_enable),
    .tstamp_fifo_warn_flag(tstamp_fifo_warn_flag), .tstamp_fifo_update_enable(tstamp_fifo_update_enable),
    .tstamp_fifo_update_flag(tstamp_fifo_update_flag), .mac_irq(mac_irq),
    .error_status_reg(error_status_reg), .error_enable_reg(error_enable_reg),
    .tx_frame_sent(tx_frame_sent), .op_mode(op_mode), .rx_frame_enable_q(rx_frame_enable_q),
    .rx_frame_flag_q(rx_frame_flag_q), .interrupt_summary(interrupt_summary),
    .tx_frame_done_flag_q(tx_frame_done_flag_q));
`default_nettype wire

// >>> verif/iss_top_tb_top.sv
// self-checking bench for the interrupt summary block
`timescale 1ns/1ps
`default_nettype none
`include "iss_params.svh"

module iss_top_tb_top;
    import iss_pkg::*;

    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        awv, wv, brdy, arv, rrdy, awr, wr, bv, arr, rv, irq;
    logic [31:0] awa, ara;
    iss_word_t   wd, rd, sum;
    iss_resp_t   br, rr;
    logic [15:1] de, df;
    logic [31:0] ge, gs, es, ee;
    logic        rwe, rwf, twe, twf, tue, tuf, mac, opm;
    logic [3:0]  ts, re, rf, txf;
    int          error_cnt = 0;
    int          samples_checked = 0;
    int          cyc = 0;

    iss_top u_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_wvalid(wv), .s_axi_wready(wr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(brdy),
        .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
        .s_axi_arprot(3'h0), .s_axi_rvalid(rv), .s_axi_rready(rrdy), .s_axi_rdata(rd),
        .s_axi_rresp(rr), .descriptor_irq_enable_n(de), .descriptor_irq_flag_n(df),
        .time_sync_irq_enable_reg(ge), .time_sync_irq_status_reg(gs), .rx_fifo_warn_enable(rwe),
        .rx_fifo_warn_flag(rwf), .tstamp_fifo_warn_enable(twe), .tstamp_fifo_warn_flag(twf),
        .tstamp_fifo_update_enable(tue), .tstamp_fifo_update_flag(tuf), .mac_irq(mac),
        .error_status_reg(es), .error_enable_reg(ee), .tx_frame_sent(ts), .op_mode(opm),
        .rx_frame_enable_q(re), .rx_frame_flag_q(rf), .interrupt_summary(sum),
        .tx_frame_done_flag_q(txf), .irq(irq));

    // 125 MHz
    always #4 aclk = ~aclk;

    // hang guard: the tests need several hundred cycles
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            results();
        end
    end

    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input iss_word_t got, input iss_word_t exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // each channel is released at the edge where its ready is seen
    task automatic axi_wr(input iss_addr_t a, input iss_word_t d, output iss_resp_t r);
        @(posedge aclk);
        awa <= {24'h0, a};
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        brdy <= 1'b1;
        do begin
            @(posedge aclk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
        end while (bv !== 1'b1);
        r = br;
        brdy <= 1'b0;
    endtask

    task automatic axi_rd(input iss_addr_t a, output iss_word_t d, output iss_resp_t r);
        @(posedge aclk);
        ara <= {24'h0, a};
        arv <= 1'b1;
        rrdy <= 1'b1;
        do begin
            @(posedge aclk);
            if (arr) arv <= 1'b0;
        end while (rv !== 1'b1);
        d = rd;
        r = rr;
        rrdy <= 1'b0;
    endtask

    // summary is compared both at the port and through the bus
    task automatic sum_chk(input iss_word_t exp);
        iss_word_t d;
        iss_resp_t r;
        repeat (3) @(posedge aclk);
        chk(sum, exp);
        axi_rd(`ISS_OFF_SUMMARY, d, r);
        chk(d, exp);
    endtask

    task automatic set_pair(input int b, input logic e, input logic f);
        @(posedge aclk);
        if (b >= 17) begin
            de[b-16] <= e;
            df[b-16] <= f;
        end
        case (b)
            12: begin rwe <= e; rwf <= f; end
            9: begin twe <= e; twf <= f; end
            8: begin tue <= e; tuf <= f; end
            6: begin ee[5] <= e; es[5] <= f; end
            0: begin re[3] <= e; rf[3] <= f; end
            default: ;
        endcase
    endtask

    // every and-type source but the transmit queue bit: enable alone, flag alone, both
    task automatic t_pairs;
        for (int b = 0; b < 32; b++) begin
            if (b inside {[17:31], 12, 9, 8, 6, 0}) begin
                set_pair(b, 1'b1, 1'b0);
                sum_chk(32'h0);
                set_pair(b, 1'b0, 1'b1);
                sum_chk(32'h0);
                set_pair(b, 1'b1, 1'b1);
                sum_chk(32'h1 << b);
                set_pair(b, 1'b0, 1'b0);
            end
        end
        // unmatched indices must not combine
        es <= 32'h8;
        ee <= 32'h10;
        rf <= 4'h4;
        re <= 4'h2;
        sum_chk(32'h0);
        {es, ee, rf, re} <= '0;
        gs <= 32'h8000_0000;
        sum_chk(32'h2000);
        gs <= 32'h0;
        ge <= 32'h1;
        sum_chk(32'h2000);
        ge <= 32'h0;
        $display("test pairs done");
    endtask

    task automatic t_irq;
        iss_word_t d;
        iss_resp_t r;
        axi_wr(`ISS_OFF_IRQ_STATUS, 32'hffff_ffff, r);
        axi_wr(`ISS_OFF_IRQ_MASK, 32'h80, r);
        sum_chk(32'h0);
        chk({31'h0, irq}, 32'h0);
        mac <= 1'b1;
        sum_chk(32'h80);
        chk({31'h0, irq}, 32'h1);
        mac <= 1'b0;
        sum_chk(32'h0);
        chk({31'h0, irq}, 32'h1);
        axi_wr(`ISS_OFF_IRQ_MASK, 32'h0, r);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        axi_wr(`ISS_OFF_IRQ_STATUS, 32'h80, r);
        axi_rd(`ISS_OFF_IRQ_STATUS, d, r);
        chk(d, 32'h0);
        $display("test irq done");
    endtask

    task automatic t_tx;
        iss_resp_t r;
        iss_word_t d;
        axi_wr(`ISS_OFF_TXDONE_EN, 32'h2, r);
        opm <= 1'b1;
        ts <= 4'h4;
        @(posedge aclk);
        ts <= 4'h0;
        sum_chk(32'h0);
        chk({28'h0, txf}, 32'h4);
        ts <= 4'h2;
        @(posedge aclk);
        ts <= 4'h0;
        sum_chk(32'h4);
        axi_wr(`ISS_OFF_TXDONE_FLAG, 32'h2, r);
        chk({28'h0, txf}, 32'h2);
        // everything on: only used positions may show
        {de, df, rwe, rwf, twe, twf, tue, tuf, mac} <= '1;
        {es, ee, re, rf, gs} <= '1;
        sum_chk(`ISS_SUMMARY_USED);
        axi_wr(`ISS_OFF_SUMMARY, 32'h0, r);
        chk({30'h0, r}, {30'h0, `ISS_RESP_OKAY});
        sum_chk(`ISS_SUMMARY_USED);
        {de, df, rwe, rwf, twe, twf, tue, tuf, mac} <= '0;
        {es, ee, re, rf, gs} <= '0;
        opm <= 1'b0;
        sum_chk(32'h0);
        chk({28'h0, txf}, 32'h0);
        axi_rd(8'h40, d, r);
        chk({30'h0, r}, {30'h0, `ISS_RESP_SLVERR});
        axi_wr(8'h40, 32'h0, r);
        chk({30'h0, r}, {30'h0, `ISS_RESP_SLVERR});
        $display("test tx done");
    endtask

    initial begin
        {awv, wv, brdy, arv, rrdy, awa, ara, wd} = '0;
        {de, df, ge, gs, es, ee} = '0;
        {rwe, rwf, twe, twf, tue, tuf, mac, opm, ts, re, rf} = '0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        sum_chk(32'h0);
        t_pairs();
        t_irq();
        t_tx();
        results();
    end
endmodule
`default_nettype wire
